// File: design/port_one_pkg.sv
package port_one_pkg;

  localparam int          PORT_W            = 8;
  localparam int          ADDR_W            = 4;

  // Register offsets
  localparam logic [3:0]  ADDR_PIN_DIRECTION  = 4'h0;
  localparam logic [3:0]  ADDR_OUTPUT_DATA    = 4'h1;
  localparam logic [3:0]  ADDR_PIN_LEVEL_VIEW = 4'h2;

  // Reset and fixed read values
  localparam logic [7:0]  RST_PIN_DIRECTION   = 8'h00;
  localparam logic [7:0]  RST_OUTPUT_DATA     = 8'h00;
  localparam logic [7:0]  DIR_READ_VALUE      = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ_VALUE = 8'h00;
  localparam logic [7:0]  RST_READ_DATA       = 8'h00;
  localparam logic [7:0]  RST_PIN_OUT         = 8'h00;
  localparam logic [7:0]  RST_PIN_OE_N        = 8'hff;
  localparam logic [7:0]  RST_SYNC            = 8'h00;

  // Pin positions of the extra input functions
  localparam int          PIN_EXT_CLK_D     = 7;
  localparam int          PIN_INT_REQ_1     = 6;
  localparam int          PIN_EXT_CLK_C     = 5;
  localparam int          PIN_INT_REQ_0     = 4;
  localparam int          PIN_EXT_CLK_B     = 3;
  localparam int          PIN_EXT_CLK_A     = 2;

  // Pin positions of the timer channels
  localparam int          CH2_LSB           = 6;
  localparam int          CH1_LSB           = 4;
  localparam int          CH0_LSB           = 0;

  typedef enum logic [1:0] {
    FUNC_INPUT,
    FUNC_PORT_OUT,
    FUNC_PULSE_OUT,
    FUNC_TIMER_OUT
  } pin_func_e;

  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

endpackage : port_one_pkg

// File: design/pin_mux_if.sv
`timescale 1ns/10ps
interface pin_mux_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] dir;
  logic [WIDTH-1:0] out_data;
  logic [WIDTH-1:0] pulse_en;
  logic [WIDTH-1:0] pulse_val;
  logic [WIDTH-1:0] timer_oe;
  logic [WIDTH-1:0] timer_val;
  logic [WIDTH-1:0] drive_val;
  logic [WIDTH-1:0] drive_en;
  logic [WIDTH-1:0] is_input;

  modport ctrl (
    output dir, out_data, pulse_en, pulse_val, timer_oe, timer_val,
    input  drive_val, drive_en, is_input
  );
  modport mux (
    input  dir, out_data, pulse_en, pulse_val, timer_oe, timer_val,
    output drive_val, drive_en, is_input
  );
endinterface : pin_mux_if

// File: design/level_sync.sv
`timescale 1ns/10ps
module level_sync
  import port_one_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  // Two stages; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg   <= WIDTH'(RST_SYNC);
      stable_reg <= WIDTH'(RST_SYNC);
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule : level_sync

// File: design/pin_func_mux.sv
`timescale 1ns/10ps
module pin_func_mux
  import port_one_pkg::*;
#(
  parameter int   WIDTH         = 8,
  parameter logic HAS_PULSE_GEN = 1'b1
) (
  pin_mux_if.mux  mx
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    pin_func_e func;
    wire       pulse_sel;

    assign pulse_sel = HAS_PULSE_GEN & mx.pulse_en[i];
    // Timer output first, then direction, then pulse enable
    assign func = mx.timer_oe[i] ? FUNC_TIMER_OUT :
                  !mx.dir[i]     ? FUNC_INPUT :
                  pulse_sel      ? FUNC_PULSE_OUT : FUNC_PORT_OUT;
    assign mx.drive_en[i]  = (func != FUNC_INPUT);
    assign mx.is_input[i]  = (func == FUNC_INPUT);
    assign mx.drive_val[i] = (func == FUNC_TIMER_OUT) ? mx.timer_val[i] :
                             (func == FUNC_PULSE_OUT) ? mx.pulse_val[i] :
                             (func == FUNC_PORT_OUT)  ? mx.out_data[i] : 1'b0;
  end

endmodule : pin_func_mux

// File: design/port_one_gpio.sv
// How it works
// - Eight-bit write-only direction register
// - Direction 1 output, 0 input, reset 0
// - Direction read returns a fixed meaningless value
// - Eight-bit read/write output data, reset 0
// - Port output drives output data bit
// - Pin view is read-only, writes ignored
// - View gives data if output, else pin
// - View follows pins through the synchronizer, reads 0 after reset
// - Timer output, then input, pulse, port
// - Input pin feeds port, capture, extra input
// - Pins 7-6 channel 2, 5-4 channel 1, 3-0 channel 0
// - Pulse enables and lines 15..8 map pins 7..0
// - No pulse function without pattern generator
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module port_one_gpio
  import port_one_pkg::*;
#(
  parameter logic HAS_PULSE_GEN = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe_n,
  input  wire logic [PORT_W-1:0] pulse_enable,
  input  wire logic [PORT_W-1:0] pulse_out,
  input  wire logic [1:0]        timer2_oe,
  input  wire logic [1:0]        timer2_out,
  input  wire logic [1:0]        timer1_oe,
  input  wire logic [1:0]        timer1_out,
  input  wire logic [3:0]        timer0_oe,
  input  wire logic [3:0]        timer0_out,
  output logic      [1:0]        timer2_cc_in,
  output logic      [1:0]        timer1_cc_in,
  output logic      [3:0]        timer0_cc_in,
  output logic      [3:0]        ext_timer_clk,
  output logic      [1:0]        ext_int_req
);

  // Register state
  logic [7:0]        pin_direction_reg;
  logic [7:0]        pin_direction_next;
  logic [7:0]        output_data_reg;
  logic [7:0]        output_data_next;
  logic [7:0]        rdata_reg;
  logic [7:0]        rdata_next;

  // Pin drive state
  logic [PORT_W-1:0] pin_out_reg;
  logic [PORT_W-1:0] pin_out_next;
  logic [PORT_W-1:0] pin_oe_n_reg;
  logic [PORT_W-1:0] pin_oe_n_next;

  // Input function state
  logic [1:0]        timer2_cc_in_reg;
  logic [1:0]        timer2_cc_next;
  logic [1:0]        timer1_cc_in_reg;
  logic [1:0]        timer1_cc_next;
  logic [3:0]        timer0_cc_in_reg;
  logic [3:0]        timer0_cc_next;
  logic [3:0]        ext_timer_clk_reg;
  logic [3:0]        ext_clk_next;
  logic [1:0]        ext_int_req_reg;
  logic [1:0]        int_req_next;

  // Pin levels
  logic [PORT_W-1:0] pin_sync;
  wire  [PORT_W-1:0] pin_view;
  wire  [PORT_W-1:0] input_level;
  wire  [PORT_W-1:0] timer_oe_all;
  wire  [PORT_W-1:0] timer_val_all;

  // Bus decode
  wire               hit_dir;
  wire               hit_out;
  wire               hit_view;
  wire               wr_dir;
  wire               wr_out;
  wire               rd_dir;
  wire               rd_out;
  wire               rd_view;
  wire  [7:0]        rdata_dir;
  wire  [7:0]        rdata_out;
  wire  [7:0]        rdata_view;

  // Extra input functions
  wire               ext_clk_a;
  wire               ext_clk_b;
  wire               ext_clk_c;
  wire               ext_clk_d;
  wire               int_req_0;
  wire               int_req_1;

  pin_mux_if #(.WIDTH(PORT_W)) mx_if ();

  level_sync #(
    .WIDTH    (PORT_W)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  pin_func_mux #(
    .WIDTH         (PORT_W),
    .HAS_PULSE_GEN (HAS_PULSE_GEN)
  ) u_mux (
    .mx            (mx_if.mux)
  );

  // Channel grouping of timer controls
  assign timer_oe_all[CH2_LSB +: 2]  = timer2_oe;
  assign timer_oe_all[CH1_LSB +: 2]  = timer1_oe;
  assign timer_oe_all[CH0_LSB +: 4]  = timer0_oe;
  assign timer_val_all[CH2_LSB +: 2] = timer2_out;
  assign timer_val_all[CH1_LSB +: 2] = timer1_out;
  assign timer_val_all[CH0_LSB +: 4] = timer0_out;

  // Interface hookup
  assign mx_if.timer_oe  = timer_oe_all;
  assign mx_if.timer_val = timer_val_all;
  assign mx_if.dir       = pin_direction_reg;
  assign mx_if.out_data  = output_data_reg;
  assign mx_if.pulse_en  = pulse_enable;
  assign mx_if.pulse_val = pulse_out;

  // Address decode
  assign hit_dir  = addr_hit(reg_addr, ADDR_PIN_DIRECTION);
  assign hit_out  = addr_hit(reg_addr, ADDR_OUTPUT_DATA);
  assign hit_view = addr_hit(reg_addr, ADDR_PIN_LEVEL_VIEW);

  // Strobe-qualified selects
  assign wr_dir  = reg_wr && hit_dir;
  assign wr_out  = reg_wr && hit_out;
  assign rd_dir  = reg_rd && hit_dir;
  assign rd_out  = reg_rd && hit_out;
  assign rd_view = reg_rd && hit_view;

  // Register next values
  assign pin_direction_next = wr_dir ? reg_wdata : pin_direction_reg;
  assign output_data_next   = wr_out ? reg_wdata : output_data_reg;

  // Per-pin view and input routing
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    wire is_out;
    wire is_in;
    wire data_bit;
    wire live_bit;
    assign is_out         = pin_direction_reg[i];
    assign is_in          = mx_if.is_input[i];
    assign data_bit       = output_data_reg[i];
    assign live_bit       = pin_sync[i];
    assign pin_view[i]    = is_out ? data_bit : live_bit;
    assign input_level[i] = is_in & live_bit;
  end

  // Read candidates
  assign rdata_dir  = DIR_READ_VALUE;
  assign rdata_out  = output_data_reg;
  assign rdata_view = pin_view;

  // Read mux; view writes fall through untouched
  assign rdata_next = rd_dir  ? rdata_dir :
                      rd_out  ? rdata_out :
                      rd_view ? rdata_view :
                      reg_rd  ? UNMAPPED_READ_VALUE :
                      RST_READ_DATA;

  // Extra inputs only while the pin is an input
  assign ext_clk_d = input_level[PIN_EXT_CLK_D];
  assign ext_clk_c = input_level[PIN_EXT_CLK_C];
  assign ext_clk_b = input_level[PIN_EXT_CLK_B];
  assign ext_clk_a = input_level[PIN_EXT_CLK_A];
  assign int_req_1 = input_level[PIN_INT_REQ_1];
  assign int_req_0 = input_level[PIN_INT_REQ_0];

  assign ext_clk_next = {ext_clk_d, ext_clk_c, ext_clk_b, ext_clk_a};
  assign int_req_next = {int_req_1, int_req_0};

  // Capture inputs by channel
  assign timer2_cc_next = input_level[CH2_LSB +: 2];
  assign timer1_cc_next = input_level[CH1_LSB +: 2];
  assign timer0_cc_next = input_level[CH0_LSB +: 4];

  // Pin drive from the function selector
  assign pin_out_next  = mx_if.drive_val;
  assign pin_oe_n_next = ~mx_if.drive_en;

  // Direction bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_direction_reg <= RST_PIN_DIRECTION;
    end else begin
      pin_direction_reg <= pin_direction_next;
    end
  end

  // Output data bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_data_reg <= RST_OUTPUT_DATA;
    end else begin
      output_data_reg <= output_data_next;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= RST_READ_DATA;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Pin drive values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out_reg <= RST_PIN_OUT;
    end else begin
      pin_out_reg <= pin_out_next;
    end
  end

  // Pin output enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_oe_n_reg <= RST_PIN_OE_N;
    end else begin
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  // Channel 2 capture inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer2_cc_in_reg <= '0;
    end else begin
      timer2_cc_in_reg <= timer2_cc_next;
    end
  end

  // Channel 1 capture inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer1_cc_in_reg <= '0;
    end else begin
      timer1_cc_in_reg <= timer1_cc_next;
    end
  end

  // Channel 0 capture inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer0_cc_in_reg <= '0;
    end else begin
      timer0_cc_in_reg <= timer0_cc_next;
    end
  end

  // External timer clocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_timer_clk_reg <= '0;
    end else begin
      ext_timer_clk_reg <= ext_clk_next;
    end
  end

  // Interrupt requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_int_req_reg <= '0;
    end else begin
      ext_int_req_reg <= int_req_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata     = rdata_reg;
  assign pin_out       = pin_out_reg;
  assign pin_oe_n      = pin_oe_n_reg;
  assign timer2_cc_in  = timer2_cc_in_reg;
  assign timer1_cc_in  = timer1_cc_in_reg;
  assign timer0_cc_in  = timer0_cc_in_reg;
  assign ext_timer_clk = ext_timer_clk_reg;
  assign ext_int_req   = ext_int_req_reg;

endmodule : port_one_gpio

// File: verification/port_one_gpio_props.sv
`timescale 1ns/10ps
module port_one_gpio_props
  import port_one_pkg::*;
#(
  parameter logic HAS_PULSE_GEN = 1'b1
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [1:0] timer2_oe,
  input wire logic [1:0] timer2_out,
  input wire logic [3:0] timer0_oe,
  input wire logic [3:0] timer0_out,
  input wire logic [1:0] timer2_cc_in,
  input wire logic [1:0] timer1_cc_in,
  input wire logic [3:0] timer0_cc_in,
  input wire logic [3:0] ext_timer_clk,
  input wire logic [1:0] ext_int_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RESET_STATE: assert property ($past(sys_rst) |-> pin_oe_n == 8'hff && reg_rdata == 8'h00)
    else $error("pins not released after reset");
  AST_DIR_READ: assert property (reg_rd && reg_addr == ADDR_PIN_DIRECTION |=> reg_rdata == 8'h00)
    else $error("direction read not fixed");
  AST_DATA_BACK: assert property (reg_wr && reg_addr == ADDR_OUTPUT_DATA ##1 reg_rd
    && reg_addr == ADDR_OUTPUT_DATA |=> reg_rdata == $past(reg_wdata, 2))
    else $error("output data not read back");
  AST_TIMER0_WINS: assert property (timer0_oe[0] |=> !pin_oe_n[0]
    && pin_out[0] == $past(timer0_out[0])) else $error("timer output not on pin 0");
  AST_TIMER2_MAP: assert property (timer2_oe[1] |=> !pin_oe_n[7]
    && pin_out[7] == $past(timer2_out[1])) else $error("timer output not on pin 7");
  AST_EXTRA_SAME: assert property ({timer2_cc_in, timer1_cc_in[1], timer0_cc_in[3:2]}
    == {ext_timer_clk[3], ext_int_req[1], ext_timer_clk[2], ext_timer_clk[1:0]})
    else $error("extra input differs from capture");
  AST_DRIVEN_NO_CAPTURE: assert property (!pin_oe_n[0] && !$past(pin_oe_n[0])
    |-> timer0_cc_in[0] == 1'b0) else $error("capture seen on driven pin");
  AST_SYNC_PATH: assert property (pin_oe_n[7] [*4] |-> ext_timer_clk[3] == $past(pin_in[7], 3))
    else $error("pin 7 input latency wrong");
endmodule : port_one_gpio_props
bind port_one_gpio port_one_gpio_props #(.HAS_PULSE_GEN(HAS_PULSE_GEN)) i_port_one_gpio_props (.*);

// File: verification/board_pins.sv
`timescale 1ns/10ps
module board_pins (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] board_level,
  output logic      [7:0] pin_in
);
  // Driven pins show the device level, released pins the board level
  assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
endmodule : board_pins

// File: verification/port_one_gpio_tb.sv
`timescale 1ns/10ps
module port_one_gpio_tb;
  import port_one_pkg::*;
  logic       clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, t0_oe = 4'h0, t0_out = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, pin_in, pin_out, pin_oe_n, board = 8'h00;
  logic [7:0] pen = 8'h00, pout = 8'h00;
  logic [1:0] t2_oe = 2'h0, t2_out = 2'h0, t1_oe = 2'h0, t1_out = 2'h0, c2, c1, irq;
  logic [3:0] c0, eclk;
  int         n_errors = 0, n_compared = 0;
  always #25 clk = ~clk;
  board_pins i_board_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_level(board),
    .pin_in(pin_in));
  port_one_gpio i_port_one_gpio (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pulse_enable(pen),
    .pulse_out(pout), .timer2_oe(t2_oe), .timer2_out(t2_out), .timer1_oe(t1_oe),
    .timer1_out(t1_out), .timer0_oe(t0_oe), .timer0_out(t0_out), .timer2_cc_in(c2),
    .timer1_cc_in(c1), .timer0_cc_in(c0), .ext_timer_clk(eclk), .ext_int_req(irq));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      reg_wr <= 1'b0;
    end
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("read data", exp, reg_rdata);
  endtask : rd
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic t_port();
    chk("oe after reset", 8'hff, pin_oe_n);
    rd(ADDR_OUTPUT_DATA, 8'h00);
    rd(ADDR_PIN_DIRECTION, DIR_READ_VALUE);
    wr(ADDR_PIN_DIRECTION, 8'hff);
    wr(ADDR_OUTPUT_DATA, 8'ha5);
    rd(ADDR_OUTPUT_DATA, 8'ha5);
    @(posedge clk);
    board <= 8'h5a;
    cyc(2);
    chk("oe", 8'h00, pin_oe_n);
    chk("pin out", 8'ha5, pin_out);
    rd(ADDR_PIN_LEVEL_VIEW, 8'ha5);
    wr(ADDR_PIN_LEVEL_VIEW, 8'h00);
    rd(ADDR_OUTPUT_DATA, 8'ha5);
    chk("pin out kept", 8'ha5, pin_out);
    rd(4'hf, UNMAPPED_READ_VALUE);
    $display("port test done");
  endtask : t_port
  task automatic t_input();
    @(posedge clk);
    board <= 8'h96;
    wr(ADDR_PIN_DIRECTION, 8'h00);
    cyc(5);
    chk("oe", 8'hff, pin_oe_n);
    rd(ADDR_PIN_LEVEL_VIEW, 8'h96);
    chk("capture", 8'h96, {c2, c1, c0});
    chk("ext clk", 8'h09, {4'h0, eclk});
    chk("irq", 8'h01, {6'h00, irq});
    wr(ADDR_PIN_DIRECTION, 8'h0f);
    cyc(5);
    rd(ADDR_PIN_LEVEL_VIEW, 8'h95);
    chk("capture driven", 8'h90, {c2, c1, c0});
    $display("input test done");
  endtask : t_input
  task automatic t_func();
    wr(ADDR_PIN_DIRECTION, 8'hff);
    pen <= 8'h0f;
    pout <= 8'h0a;
    t0_oe <= 4'h1;
    t0_out <= 4'h1;
    t1_oe <= 2'h1;
    t1_out <= 2'h1;
    t2_oe <= 2'h2;
    cyc(2);
    chk("timer mix", 8'h3b, pin_out);
    @(posedge clk);
    {t0_oe, t1_oe, t2_oe} <= 8'h00;
    cyc(2);
    chk("pulse mix", 8'haa, pin_out);
    chk("oe", 8'h00, pin_oe_n);
    $display("function test done");
  endtask : t_func
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(1);
    t_port();
    t_input();
    t_func();
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : port_one_gpio_tb
